/* timed_io_port.sv */
// Functional notes
// [RL1] Ports of width 1, 4, 8, 16 and 32.
// [RL2] One direction for all pins of a port.
// [RL3] Drive pins, or sample with optional condition.
// [RL4] Open collector: zero pulls low, one floats.
// [RL5] Every access completes in one cycle.
// [RL6] Serializer stage plus transfer register buffer data.
// [RL7] Sixteen-bit counter times each transfer.
// [RL8] Counter readable; future time delays transfer.
// [RL9] Counter captured as timestamp per transfer.
// [RL10] Enabled link disables ports on shared pins.
// [RL11] Narrowest enabled port owns shared pins.
// [RL12] Unclaimed pins stay with the wider port.
// [RL13] Ports always transfer at full width.
// [RL14] Six clock blocks; block zero is reference.
// [RL15] Clock block may run from divided pin.
// [RL16] Strobe input qualifies, strobe output marks data.
// [RL17] After reset all ports use block zero.
// [RL18] Pin conditions raise events to scheduler.
// [RL19] Pull-downs enabled while in reset.
// [RL20] Counter steps per clock block tick, wraps.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "tio_map.svh"
module timed_io_port #(
    parameter int unsigned PORT_W [`TIO_NPORT] = '{1, 4, 8, 16, 32},
    parameter logic [`TIO_PINS-1:0] LINK_MASK = 32'h3ff0_0000
) (
    input wire logic MCLK_I,
    input wire logic RESET_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [`TIO_PINS-1:0] PIN_I,
    output logic [`TIO_PINS-1:0] PIN_O,
    output logic [`TIO_PINS-1:0] PIN_OE_O,
    output logic PIN_PULLDOWN_O,
    input wire logic [`TIO_PINS-1:0] LINK_TX_I,
    input wire logic [`TIO_PINS-1:0] LINK_OE_I,
    input wire logic [`TIO_NPORT-1:0] STROBE_INPUT_I,
    output logic [`TIO_NPORT-1:0] STROBE_OUTPUT_O,
    output logic [`TIO_NPORT-1:0] EVENT_O
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    tio_pkg::state_t st_q;
    tio_pkg::state_t st_d;

    // Reset is applied at once and released through two flip-flops.
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    function automatic logic [31:0] width_mask(input int unsigned w);
        width_mask = (w >= 32) ? 32'hffff_ffff : ((32'h1 << w) - 32'h1);
    endfunction

    always_comb begin
        logic [7:0] tick;
        logic [`TIO_NPORT-1:0] cap;
        logic ev;
        logic go;
        logic [31:0] pv;
        logic [31:0] msk;
        logic [5:0] last;
        int unsigned w;
        int own;
        logic [2:0] pidx;
        logic [2:0] ridx;
        logic [5:0] cidx;
        logic hit;
        logic [31:0] rd;
        logic setup;
        logic acc;
        st_d = st_q;
        tick = 8'h00;
        cap = '0;
        ev = 1'b0;
        go = 1'b0;
        pv = 32'h0;
        msk = 32'h0;
        last = 6'h0;
        w = 0;
        own = 0;
        hit = 1'b0;
        rd = 32'h0;
        setup = PSEL_I && !PENABLE_I;
        acc = PSEL_I && PENABLE_I;
        pidx = PADDR_I[7:5];
        ridx = PADDR_I[4:2];
        cidx = PADDR_I[7:2];

        // Pin and strobe inputs pass two flip-flops before use.
        st_d.pin_s1 = PIN_I;
        st_d.pin_s2 = st_q.pin_s1;
        st_d.stb_s1 = STROBE_INPUT_I;
        st_d.stb_s2 = st_q.stb_s1;
        st_d.clk_prev = st_q.pin_s2[0];

        // Clock blocks: block zero always ticks at the reference rate.
        for (int b = 0; b < `TIO_NCB; b++) begin
            ev = 1'b1; // RL14
            if (b != 0 && st_q.cb[b].src) begin
                ev = st_q.pin_s2[0] && !st_q.clk_prev; // RL15
            end
            tick[b] = ev && (st_q.cb[b].cnt == st_q.cb[b].div); // RL15
            if (ev) begin
                st_d.cb[b].cnt = tick[b] ? 8'h00 : st_q.cb[b].cnt + 8'h01;
            end
        end

        for (int i = 0; i < `TIO_NPORT; i++) begin
            w = PORT_W[i]; // RL1
            msk = width_mask(w);
            last = 6'(32 / w - 1); // RL13
            pv = st_q.pin_s2 & msk;
            st_d.ports[i].evt = 1'b0;
            // The strobe is registered so that it lines up with the registered pins.
            st_d.stb_o[i] = st_q.ports[i].strb && st_q.ports[i].shv && st_q.ports[i].out; // RL16
            if (st_q.ports[i].en && tick[st_q.ports[i].cb]) begin
                st_d.ports[i].cnt = st_q.ports[i].cnt + 16'h0001; // RL20
                go = !st_q.ports[i].tarm || (st_q.ports[i].cnt == st_q.ports[i].tim); // RL8
                if (st_q.ports[i].out) begin
                    // Output: the serializer shifts one port width per tick.
                    if (st_q.ports[i].shv && st_q.ports[i].beat != last) begin
                        st_d.ports[i].sh = st_q.ports[i].sh >> w; // RL6
                        st_d.ports[i].beat = st_q.ports[i].beat + 6'h01;
                    end else if (st_q.ports[i].txv && go) begin
                        st_d.ports[i].sh = st_q.ports[i].txr; // RL6
                        st_d.ports[i].beat = 6'h00;
                        st_d.ports[i].shv = 1'b1;
                        st_d.ports[i].txv = 1'b0;
                        st_d.ports[i].tarm = 1'b0; // RL7
                        st_d.ports[i].ts = st_q.ports[i].cnt; // RL9
                    end else begin
                        st_d.ports[i].shv = 1'b0;
                    end
                end else if (!st_q.ports[i].strb || st_q.stb_s2[i]) begin // RL16
                    // Input: a word starts only once its condition holds.
                    if (st_q.ports[i].beat == 6'h00) begin
                        unique case (st_q.ports[i].cond) // RL3
                            tio_pkg::COND_EQ: go = go && (pv == (st_q.ports[i].condv & msk));
                            tio_pkg::COND_NEQ: go = go && (pv != (st_q.ports[i].condv & msk));
                            default: go = go;
                        endcase
                    end else begin
                        go = 1'b1;
                    end
                    if (go) begin
                        st_d.ports[i].sh = (st_q.ports[i].sh >> w) | (pv << (32 - w)); // RL6
                        st_d.ports[i].beat = st_q.ports[i].beat + 6'h01;
                        if (st_q.ports[i].beat == last) begin
                            st_d.ports[i].beat = 6'h00;
                            st_d.ports[i].rxr = (st_q.ports[i].sh >> w) | (pv << (32 - w));
                            st_d.ports[i].rxv = 1'b1;
                            st_d.ports[i].fresh = 1'b1;
                            st_d.ports[i].tarm = 1'b0; // RL7
                            st_d.ports[i].ts = st_q.ports[i].cnt; // RL9
                            st_d.ports[i].evt = 1'b1; // RL18
                            cap[i] = 1'b1;
                        end
                    end
                end
            end
        end

        // Pin ownership: link first, then the narrowest enabled port.
        for (int p = 0; p < `TIO_PINS; p++) begin
            own = -1;
            for (int i = `TIO_NPORT - 1; i >= 0; i--) begin
                if (st_q.ports[i].en && p < int'(PORT_W[i])) begin
                    own = i; // RL11 RL12
                end
            end
            st_d.pin_o[p] = 1'b0;
            st_d.pin_oe[p] = 1'b0;
            if (st_q.link_en && LINK_MASK[p]) begin
                st_d.pin_o[p] = LINK_TX_I[p]; // RL10
                st_d.pin_oe[p] = LINK_OE_I[p]; // RL10
            end else if (own >= 0) begin
                if (st_q.ports[own].out) begin // RL2
                    st_d.pin_o[p] = st_q.ports[own].oc ? 1'b0 : st_q.ports[own].sh[p];
                    st_d.pin_oe[p] = !st_q.ports[own].oc || !st_q.ports[own].sh[p]; // RL4
                end
            end
        end

        // Register bus decode and read data, latched in the setup cycle.
        if (PADDR_I[11:8] == `TIO_AREA_PORT && pidx < `TIO_NPORT && ridx <= `TIO_REG_STAT) begin
            hit = 1'b1;
            unique case (ridx)
                `TIO_REG_CTRL: begin
                    rd[`TIO_CTRL_EN] = st_q.ports[pidx].en;
                    rd[`TIO_CTRL_OUT] = st_q.ports[pidx].out;
                    rd[`TIO_CTRL_OC] = st_q.ports[pidx].oc;
                    rd[`TIO_CTRL_STRB] = st_q.ports[pidx].strb;
                    rd[`TIO_CTRL_CB_LSB +: 3] = st_q.ports[pidx].cb;
                    rd[`TIO_CTRL_COND_LSB +: 2] = st_q.ports[pidx].cond;
                end
                `TIO_REG_DATA: rd = st_q.ports[pidx].rxr;
                `TIO_REG_COND: rd = st_q.ports[pidx].condv;
                `TIO_REG_TIME: rd = {16'h0000, st_q.ports[pidx].cnt}; // RL8
                `TIO_REG_TSTAMP: rd = {16'h0000, st_q.ports[pidx].ts}; // RL9
                default: begin
                    rd[0] = st_q.ports[pidx].rxv;
                    rd[1] = st_q.ports[pidx].txv;
                    rd[2] = st_q.ports[pidx].tarm;
                    rd[3] = st_q.ports[pidx].shv;
                end
            endcase
        end else if (PADDR_I[11:8] == `TIO_AREA_CLK && cidx < `TIO_NCB) begin
            hit = 1'b1;
            rd[`TIO_CB_SRC] = st_q.cb[cidx].src;
            rd[7:0] = st_q.cb[cidx].div;
        end else if (PADDR_I[11:8] == `TIO_AREA_CLK && cidx == `TIO_LINK_IDX) begin
            hit = 1'b1;
            rd[0] = st_q.link_en;
        end

        if (setup) begin
            st_d.prdata = rd;
            st_d.slverr = !hit;
            if (hit && PADDR_I[11:8] == `TIO_AREA_PORT && ridx == `TIO_REG_DATA
                && !cap[pidx]) begin
                st_d.ports[pidx].fresh = 1'b0;
            end
        end

        // Writes and read side effects take place at the access edge.
        if (acc && hit && PADDR_I[11:8] == `TIO_AREA_PORT) begin
            if (PWRITE_I) begin
                unique case (ridx)
                    `TIO_REG_CTRL: begin
                        st_d.ports[pidx].en = PWDATA_I[`TIO_CTRL_EN];
                        st_d.ports[pidx].out = PWDATA_I[`TIO_CTRL_OUT]; // RL2
                        st_d.ports[pidx].oc = PWDATA_I[`TIO_CTRL_OC]; // RL4
                        st_d.ports[pidx].strb = PWDATA_I[`TIO_CTRL_STRB];
                        st_d.ports[pidx].cb = (PWDATA_I[`TIO_CTRL_CB_LSB +: 3] < 3'(`TIO_NCB))
                            ? PWDATA_I[`TIO_CTRL_CB_LSB +: 3] : 3'h0;
                        st_d.ports[pidx].cond =
                            tio_pkg::cond_mode_t'(PWDATA_I[`TIO_CTRL_COND_LSB +: 2]);
                        st_d.ports[pidx].beat = 6'h00;
                    end
                    `TIO_REG_DATA: begin
                        st_d.ports[pidx].txr = PWDATA_I;
                        st_d.ports[pidx].txv = 1'b1;
                    end
                    `TIO_REG_COND: st_d.ports[pidx].condv = PWDATA_I;
                    `TIO_REG_TIME: begin
                        st_d.ports[pidx].tim = PWDATA_I[15:0]; // RL8
                        st_d.ports[pidx].tarm = 1'b1;
                    end
                    default: st_d.ports[pidx].tarm = st_d.ports[pidx].tarm;
                endcase
            end else if (ridx == `TIO_REG_DATA && !st_q.ports[pidx].fresh && !cap[pidx]) begin
                st_d.ports[pidx].rxv = 1'b0;
            end
        end else if (acc && hit && PWRITE_I && cidx < `TIO_NCB && cidx != 6'h00) begin
            st_d.cb[cidx].src = PWDATA_I[`TIO_CB_SRC]; // RL15
            st_d.cb[cidx].div = PWDATA_I[7:0];
            st_d.cb[cidx].cnt = 8'h00;
        end else if (acc && hit && PWRITE_I && cidx == `TIO_LINK_IDX) begin
            st_d.link_en = PWDATA_I[0]; // RL10
        end
    end

    // All state clears to zero: ports off and on clock block zero.
    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0; // RL17
        end else begin
            st_q <= st_d;
        end
    end

    assign PRDATA_O = st_q.prdata;
    assign PREADY_O = 1'b1; // RL5
    assign PSLVERR_O = st_q.slverr;
    assign PIN_O = st_q.pin_o;
    assign PIN_OE_O = st_q.pin_oe;
    assign PIN_PULLDOWN_O = !rst_n; // RL19
    assign EVENT_O = {st_q.ports[4].evt, st_q.ports[3].evt, st_q.ports[2].evt,
                      st_q.ports[1].evt, st_q.ports[0].evt};
    assign STROBE_OUTPUT_O = st_q.stb_o; // RL16
endmodule

/* tio_map.svh */
`ifndef TIO_MAP_SVH
`define TIO_MAP_SVH

// Register bus address fields: area codes, register word indices and the link index.
`define TIO_AREA_PORT 4'h0
`define TIO_AREA_CLK 4'h1
`define TIO_REG_CTRL 3'h0
`define TIO_REG_DATA 3'h1
`define TIO_REG_COND 3'h2
`define TIO_REG_TIME 3'h3
`define TIO_REG_TSTAMP 3'h4
`define TIO_REG_STAT 3'h5
`define TIO_LINK_IDX 6'h08

// Port control fields.
`define TIO_CTRL_EN 0
`define TIO_CTRL_OUT 1
`define TIO_CTRL_OC 2
`define TIO_CTRL_STRB 3
`define TIO_CTRL_CB_LSB 4
`define TIO_CTRL_COND_LSB 8

// Clock block fields.
`define TIO_CB_SRC 8

// Sizes.
`define TIO_PINS 32
`define TIO_NPORT 5
`define TIO_NCB 6
`define TIO_CNT_W 16

`endif

/* tio_pkg.sv */
package tio_pkg;
`include "tio_map.svh"

    typedef enum logic [1:0] {COND_NONE, COND_EQ, COND_NEQ, COND_SPARE} cond_mode_t;

    typedef struct packed {
        logic en;
        logic out;
        logic oc;
        logic strb;
        logic [2:0] cb;
        cond_mode_t cond;
        logic [31:0] condv;
        logic [`TIO_CNT_W-1:0] cnt;
        logic [`TIO_CNT_W-1:0] tim;
        logic tarm;
        logic [31:0] txr;
        logic txv;
        logic [31:0] sh;
        logic [5:0] beat;
        logic shv;
        logic [31:0] rxr;
        logic rxv;
        logic fresh;
        logic [`TIO_CNT_W-1:0] ts;
        logic evt;
    } port_st_t;

    typedef struct packed {
        logic src;
        logic [7:0] div;
        logic [7:0] cnt;
    } cb_st_t;

    typedef struct packed {
        port_st_t [`TIO_NPORT-1:0] ports;
        cb_st_t [`TIO_NCB-1:0] cb;
        logic link_en;
        logic [`TIO_PINS-1:0] pin_s1;
        logic [`TIO_PINS-1:0] pin_s2;
        logic clk_prev;
        logic [`TIO_NPORT-1:0] stb_s1;
        logic [`TIO_NPORT-1:0] stb_s2;
        logic [`TIO_PINS-1:0] pin_o;
        logic [`TIO_PINS-1:0] pin_oe;
        logic [`TIO_NPORT-1:0] stb_o;
        logic [31:0] prdata;
        logic slverr;
    } state_t;
endpackage

/* tio_chk_sva.sv */
`timescale 1ns/1ps
module tio_chk (
    input wire logic MCLK_I,
    input wire logic RESET_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic [31:0] PIN_O,
    input wire logic [31:0] PIN_OE_O,
    input wire logic PIN_PULLDOWN_O,
    input wire logic [4:0] STROBE_OUTPUT_O,
    input wire logic [4:0] EVENT_O
);
    logic setup;
    assign setup = PSEL_I && !PENABLE_I;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RESET_N_I);
    chk_pready_high: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
        else $error("ready low in access phase");
    chk_rdata_stands: assert property (!setup |=> $stable(PRDATA_O))
        else $error("read data changed outside setup");
    chk_err_stands: assert property (!setup |=> $stable(PSLVERR_O))
        else $error("error flag changed outside setup");
    chk_err_zero: assert property (PSLVERR_O |-> PRDATA_O == 32'h0)
        else $error("refused access returned data");
    chk_pull_release: assert property ($rose(RESET_N_I) |->
        PIN_PULLDOWN_O [*2] ##1 !PIN_PULLDOWN_O)
        else $error("pull-down release timing wrong");
    chk_reset_quiet: assert property (PIN_PULLDOWN_O |->
        PIN_OE_O == 32'h0 && PIN_O == 32'h0 && EVENT_O == 5'h0 && STROBE_OUTPUT_O == 5'h0)
        else $error("activity while pull-downs on");
    chk_gap_one: assert property (EVENT_O[0] |=> !EVENT_O[0] [*8])
        else $error("one-bit port word too short");
    chk_gap_four: assert property (EVENT_O[1] |=> !EVENT_O[1] [*7])
        else $error("four-bit port word too short");
    chk_gap_eight: assert property (EVENT_O[2] |=> !EVENT_O[2] [*3])
        else $error("eight-bit port word too short");
    cover property (EVENT_O[2]);
    cover property (PSLVERR_O);
    cover property (STROBE_OUTPUT_O[4]);
endmodule
bind timed_io_port tio_chk u_chk (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .PIN_O(PIN_O), .PIN_OE_O(PIN_OE_O), .PIN_PULLDOWN_O(PIN_PULLDOWN_O),
    .STROBE_OUTPUT_O(STROBE_OUTPUT_O), .EVENT_O(EVENT_O));

/* tio_ext.sv */
`timescale 1ns/1ps
module tio_ext (
    input wire logic clk_i,
    input wire logic [31:0] pin_o_i,
    input wire logic [31:0] pin_oe_i,
    input wire logic pulldown_i,
    input wire logic [31:0] ext_val_i,
    input wire logic ext_drive_i,
    output logic [31:0] pin_i_o,
    output logic [4:0] strobe_o
);
    logic [31:0] last_q = 32'h0;
    always_ff @(posedge clk_i) begin
        last_q <= pin_i_o;
    end
    // A floating pin reads zero under pull-down, else the inverse of its last level so stale values never pass.
    always_comb begin
        for (int b = 0; b < 32; b++) begin
            if (pin_oe_i[b])
                pin_i_o[b] = pin_o_i[b];
            else if (ext_drive_i)
                pin_i_o[b] = ext_val_i[b];
            else if (pulldown_i)
                pin_i_o[b] = 1'b0;
            else
                pin_i_o[b] = ~last_q[b];
        end
    end
    assign strobe_o = {5{ext_drive_i}};
endmodule

/* timed_io_port_with_clock_blocks_bench.sv */
`timescale 1ns/1ps
module timed_io_port_with_clock_blocks_bench;
    localparam logic [31:0] LM = 32'h3ff0_0000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwrite = 1'b0;
    logic edrv = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, ltx = 32'h0, loe = 32'h0, ev = 32'h0;
    logic [31:0] prdata, pin_o, pin_oe, pin_i, rd, w, t;
    logic [15:0] tg;
    logic pready, perr, pdn, er;
    logic [4:0] sin, sout, evt, so;
    int failures = 0;
    int cmp_count = 0;
    int seed = 16;
    int ctrl_m [5];

    timed_io_port #(.LINK_MASK(LM)) dut (.MCLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr), .PIN_I(pin_i),
        .PIN_O(pin_o), .PIN_OE_O(pin_oe), .PIN_PULLDOWN_O(pdn), .LINK_TX_I(ltx),
        .LINK_OE_I(loe), .STROBE_INPUT_I(sin), .STROBE_OUTPUT_O(sout), .EVENT_O(evt));
    tio_ext ext (.clk_i(clk), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .pulldown_i(pdn),
        .ext_val_i(ev), .ext_drive_i(edrv), .pin_i_o(pin_i), .strobe_o(sin));

    initial begin
        forever #50 clk = ~clk;
    end

    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [11:0] ad(input int p, input int off);
        return 12'(p * 32 + off);
    endfunction

    // Called just after a rising edge; returns just after the edge that follows the access.
    task bus(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pen <= 1'b0;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        check({31'h0, n >= 50}, 32'h0, "ready timeout");
        rd = prdata;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    task wr(input int p, input int off, input logic [31:0] d);
        bus(1'b1, ad(p, off), d);
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] e, input string s);
        bus(1'b0, a, 32'h0);
        check(rd, e, s);
        check({31'h0, er}, 32'h0, "error flag");
    endtask

    task pins(input logic [31:0] eo, input logic [31:0] eoe, input logic [31:0] m, input string s);
        int n;
        n = 0;
        @(negedge clk);
        while (((pin_o & m) !== eo || pin_oe !== eoe) && n < 60) begin
            @(negedge clk);
            n++;
        end
        so = sout;
        check(pin_o & m, eo, s);
        check(pin_oe, eoe, s);
        @(posedge clk);
    endtask

    task wait_evt(input int k);
        int n;
        n = 0;
        @(negedge clk);
        while (evt[k] !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check({31'h0, evt[k]}, 32'h1, "input event");
        @(posedge clk);
    endtask

    initial begin
        #2000000;
        failures++;
        test_done;
    end

    initial begin
        repeat (12) @(posedge clk);
        check({31'h0, pdn}, 32'h1, "pull-down in reset");
        check(pin_oe, 32'h0, "drive in reset");
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int p = 0; p < 5; p++) begin
            rdchk(ad(p, 0), 32'h0, "control after reset");
        end
        $display("reset test done");
        for (int p = 0; p < 5; p++) begin
            w = $random(seed) & 32'h17f;
            ctrl_m[p] = (w[6:4] > 3'd5) ? int'(w & 32'h10f) : int'(w);
            wr(p, 0, w);
            rdchk(ad(p, 0), 32'(ctrl_m[p]), "control readback");
            wr(p, 0, 32'h0);
        end
        bus(1'b0, 12'h200, 32'h0);
        check(rd, 32'h0, "unmapped data");
        check({31'h0, er}, 32'h1, "unmapped error");
        $display("register test done");
        wr(4, 0, 32'hb);
        w = $random(seed);
        wr(4, 4, w);
        pins(w, 32'hffff_ffff, 32'hffff_ffff, "output word");
        check({31'h0, so[4]}, 32'h1, "output strobe");
        bus(1'b0, ad(4, 12), 32'h0);
        t = rd;
        repeat (5) @(posedge clk);
        rdchk(ad(4, 12), {16'h0, t[15:0] + 16'h8}, "counter step");
        bus(1'b0, ad(4, 12), 32'h0);
        tg = rd[15:0] + 16'd40;
        wr(4, 12, {16'h0, tg});
        t = w;
        w = $random(seed);
        wr(4, 4, w);
        repeat (10) @(posedge clk);
        check(pin_o, t, "held until time");
        pins(w, 32'hffff_ffff, 32'hffff_ffff, "timed word");
        rdchk(ad(4, 16), {16'h0, tg}, "timestamp");
        bus(1'b1, 12'h104, 32'h3);
        rdchk(12'h104, 32'h3, "clock block divide");
        wr(4, 0, 32'h13);
        bus(1'b0, ad(4, 12), 32'h0);
        t = rd;
        repeat (13) @(posedge clk);
        rdchk(ad(4, 12), {16'h0, t[15:0] + 16'h4}, "divided counter");
        $display("output test done");
        wr(4, 0, 32'h7);
        w = $random(seed);
        wr(4, 4, w);
        pins(32'h0, ~w, ~w, "open collector");
        wr(4, 0, 32'h3);
        wr(0, 0, 32'h3);
        wr(0, 4, 32'hffff_ffff);
        w = $random(seed) & 32'hffff_fffe;
        wr(4, 4, w);
        pins(w | 32'h1, 32'hffff_ffff, 32'hffff_ffff, "shared pins");
        ltx <= $random(seed);
        loe <= $random(seed);
        bus(1'b1, 12'h120, 32'h1);
        pins((ltx & LM) | (w & ~LM) | 32'h1, (loe & LM) | ~LM, 32'hffff_ffff, "link");
        bus(1'b1, 12'h120, 32'h0);
        $display("sharing test done");
        wr(0, 0, 32'h0);
        wr(4, 0, 32'h0);
        ev <= $random(seed);
        edrv <= 1'b1;
        wr(0, 0, 32'h1);
        wr(1, 0, 32'h1);
        wr(2, 0, 32'h9);
        wait_evt(2);
        wait_evt(2);
        rdchk(ad(2, 4), {4{ev[7:0]}}, "input word");
        wait_evt(1);
        rdchk(ad(1, 4), {8{ev[3:0]}}, "four-bit word");
        wr(2, 8, {24'h0, ev[7:0]});
        wr(2, 0, 32'h209);
        bus(1'b0, ad(2, 16), 32'h0);
        t = rd;
        repeat (12) @(posedge clk);
        rdchk(ad(2, 16), t, "condition holds off");
        wr(2, 0, 32'h109);
        wait_evt(2);
        $display("input test done");
        test_done;
    end
endmodule
